//--- design/cmv_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "cmv_defines.svh"
module cmv_regs (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire cmv_pkg::cmv_req_s req_i,
  input wire logic [1:0] cell_count_select_pin_i,
  input wire logic input_power_good_i,
  input wire logic charge_current_write_i,
  output logic [7:0] rdata_o,
  output logic rvalid_o,
  output cmv_pkg::cmv_cv_t charge_voltage_setting_o,
  output cmv_pkg::cmv_ms_t system_floor_voltage_setting_o,
  output logic charge_current_clear_o,
  output logic charge_start_o,
  output logic charge_voltage_programmed_o,
  output logic write_rejected_o
);

  function automatic cmv_pkg::cmv_cv_t cv_default(input logic [1:0] cells);
    cmv_pkg::cmv_cv_t v;
    v = `CMV_CV_DEF_1S;
    unique case (cells)
      2'h0: v = `CMV_CV_DEF_1S;
      2'h1: v = `CMV_CV_DEF_2S;
      2'h2: v = `CMV_CV_DEF_3S;
      2'h3: v = `CMV_CV_DEF_4S;
    endcase
    return v;
  endfunction : cv_default

  function automatic cmv_pkg::cmv_ms_t ms_default(input logic [1:0] cells);
    cmv_pkg::cmv_ms_t v;
    v = `CMV_MS_DEF_1S;
    unique case (cells)
      2'h0: v = `CMV_MS_DEF_1S;
      2'h1: v = `CMV_MS_DEF_2S;
      2'h2: v = `CMV_MS_DEF_3S;
      2'h3: v = `CMV_MS_DEF_4S;
    endcase
    return v;
  endfunction : ms_default

  cmv_pkg::cmv_cv_t cv_q;
  cmv_pkg::cmv_cv_t cv_d;
  cmv_pkg::cmv_ms_t ms_q;
  cmv_pkg::cmv_ms_t ms_d;
  logic [7:0] cv_lo_q;
  logic load_pending_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic clear_q;
  logic start_q;
  logic programmed_q;
  logic programmed_d;
  logic reject_q;

  // Address decode
  wire logic wr_cv_lo;
  wire logic wr_cv_hi;
  wire logic wr_ms_hi;
  assign wr_cv_lo = req_i.wr && (req_i.addr == `CMV_ADDR_CV_LO);
  assign wr_cv_hi = req_i.wr && (req_i.addr == `CMV_ADDR_CV_HI);
  assign wr_ms_hi = req_i.wr && (req_i.addr == `CMV_ADDR_MS_HI);

  // Assembled 16-bit charge voltage command; floor voltage field taken from the high byte alone
  wire logic [15:0] cv_cmd;
  wire cmv_pkg::cmv_cv_t cv_field;
  wire cmv_pkg::cmv_ms_t ms_field;
  wire logic cv_rsvd;
  wire logic ms_rsvd;
  wire logic cv_zero;
  wire logic cv_ok;
  wire logic ms_ok;
  assign cv_cmd = {req_i.data, cv_lo_q};
  assign cv_field = {cv_cmd[14:8], cv_cmd[7:4]};
  assign ms_field = req_i.data[5:0];
  assign cv_rsvd = |(req_i.data & `CMV_CV_HI_RSVD);
  assign ms_rsvd = |(req_i.data & `CMV_MS_HI_RSVD);
  assign cv_zero = (cv_field == '0) && !cv_rsvd;

  cmv_field_check #(
    .W(11),
    .MIN_CODE(`CMV_CV_MIN),
    .MAX_CODE(`CMV_CV_MAX)
  ) u_cv_check (
    .field_i(cv_field),
    .rsvd_set_i(cv_rsvd),
    .ok_o(cv_ok)
  );

  cmv_field_check #(
    .W(6),
    .MIN_CODE(`CMV_MS_MIN),
    .MAX_CODE(`CMV_MS_MAX)
  ) u_ms_check (
    .field_i(ms_field),
    .rsvd_set_i(ms_rsvd),
    .ok_o(ms_ok)
  );

  wire logic cv_accept;
  wire logic cv_restore;
  wire logic ms_accept;
  wire logic any_reject;
  assign cv_accept = wr_cv_hi && cv_ok && !load_pending_q;
  assign cv_restore = wr_cv_hi && cv_zero && !load_pending_q;
  assign ms_accept = wr_ms_hi && ms_ok && !load_pending_q;
  assign any_reject = (wr_cv_hi && !cv_ok && !cv_zero) || (wr_ms_hi && !ms_ok);

  // Next setting values
  always_comb begin
    cv_d = cv_q;
    if (load_pending_q) begin
      cv_d = cv_default(cell_count_select_pin_i);
    end else if (cv_restore) begin
      cv_d = cv_default(cell_count_select_pin_i);
    end else if (cv_accept) begin
      cv_d = cv_field;
    end
  end

  always_comb begin
    ms_d = ms_q;
    if (load_pending_q) begin
      ms_d = ms_default(cell_count_select_pin_i);
    end else if (ms_accept) begin
      ms_d = ms_field;
    end
  end

  // Voltage programmed since input power became good
  always_comb begin
    programmed_d = programmed_q;
    if (!input_power_good_i) begin
      programmed_d = 1'b0;
    end else if (cv_accept) begin
      programmed_d = 1'b1;
    end
  end

  // Read mux, reserved bits read zero
  always_comb begin
    rdata_d = 8'h00;
    unique case (req_i.addr)
      `CMV_ADDR_CV_LO: rdata_d = {cv_q[3:0], 4'h0};
      `CMV_ADDR_CV_HI: rdata_d = {1'b0, cv_q[10:4]};
      `CMV_ADDR_MS_HI: rdata_d = {2'h0, ms_q};
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cv_q <= '0;
      ms_q <= '0;
      load_pending_q <= 1'b1;
    end else begin
      cv_q <= cv_d;
      ms_q <= ms_d;
      load_pending_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      cv_lo_q <= 8'h00;
    end else if (wr_cv_lo) begin
      cv_lo_q <= req_i.data;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= req_i.rd ? rdata_d : rdata_q;
      rvalid_q <= req_i.rd;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      clear_q <= 1'b0;
      start_q <= 1'b0;
      programmed_q <= 1'b0;
      reject_q <= 1'b0;
    end else begin
      clear_q <= cv_restore;
      start_q <= charge_current_write_i && input_power_good_i && !cv_restore;
      programmed_q <= programmed_d;
      reject_q <= any_reject;
    end
  end

  assign rdata_o = rdata_q;
  assign rvalid_o = rvalid_q;
  assign charge_voltage_setting_o = cv_q;
  assign system_floor_voltage_setting_o = ms_q;
  assign charge_current_clear_o = clear_q;
  assign charge_start_o = start_q;
  assign charge_voltage_programmed_o = programmed_q;
  assign write_rejected_o = reject_q;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  sequence s_cv_hi_read;
    req_i.rd && (req_i.addr == `CMV_ADDR_CV_HI);
  endsequence

  sequence s_cv_read_back;
    rvalid_o && (rdata_o == {1'b0, charge_voltage_setting_o[10:4]});
  endsequence

  property p_cv_accept;
    cv_accept && !cv_restore |=> charge_voltage_setting_o == $past(cv_field);
  endproperty
  a_cv_accept: assert property (p_cv_accept) else $error("charge voltage not stored");

  property p_cv_reject;
    wr_cv_hi && !cv_ok && !cv_zero && !load_pending_q
      |=> $stable(charge_voltage_setting_o) && write_rejected_o;
  endproperty
  a_cv_reject: assert property (p_cv_reject) else $error("bad charge voltage stored");

  property p_cv_load;
    load_pending_q |=> charge_voltage_setting_o == cv_default($past(cell_count_select_pin_i));
  endproperty
  a_cv_load: assert property (p_cv_load) else $error("charge voltage default wrong");

  property p_ms_load;
    load_pending_q |=> system_floor_voltage_setting_o == ms_default($past(cell_count_select_pin_i));
  endproperty
  a_ms_load: assert property (p_ms_load) else $error("floor voltage default wrong");

  property p_start;
    charge_current_write_i && input_power_good_i && !cv_restore |=> charge_start_o ##1 !charge_start_o || $past(charge_current_write_i);
  endproperty
  a_start: assert property (p_start) else $error("charge start missing");

  property p_zero;
    cv_restore |=> charge_current_clear_o && !charge_start_o
      && charge_voltage_setting_o == cv_default($past(cell_count_select_pin_i));
  endproperty
  a_zero: assert property (p_zero) else $error("zero write not handled");

  property p_rsvd;
    (wr_cv_hi && cv_rsvd) || (wr_ms_hi && ms_rsvd) |=> write_rejected_o
      && $stable(charge_voltage_setting_o) && $stable(system_floor_voltage_setting_o);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit write accepted");

  property p_ms_range;
    wr_ms_hi && !load_pending_q |=> (system_floor_voltage_setting_o >= `CMV_MS_MIN)
      && ($past(ms_ok) ? (system_floor_voltage_setting_o == $past(ms_field))
        : ($stable(system_floor_voltage_setting_o) && write_rejected_o));
  endproperty
  a_ms_range: assert property (p_ms_range) else $error("floor voltage out of range");

  property p_cv_read;
    s_cv_hi_read ##0 !cv_accept && !cv_restore |=> s_cv_read_back;
  endproperty
  a_cv_read: assert property (p_cv_read) else $error("charge voltage readback wrong");

  property p_ms_read;
    req_i.rd && (req_i.addr == `CMV_ADDR_MS_LO) |=> rvalid_o && (rdata_o == 8'h00);
  endproperty
  a_ms_read: assert property (p_ms_read) else $error("floor low byte not zero");

endmodule : cmv_regs
`default_nettype wire

//--- inc/cmv_defines.svh
// Notes on behaviour
// - Each voltage setting is one 16-bit command made of a low byte and a high byte at adjacent addresses.
// - Charge voltage writes from 1.024 V to 19.200 V in 16 mV steps are accepted.
// - Nonzero charge voltage writes below 1.024 V or above 19.200 V are discarded.
// - At power-on the charge voltage loads 4192, 8400, 12592 or 16800 mV from the cell-count pin.
// - Once input power is good, a charge current write starts charging right after that write unless a zero charge voltage write lands in the same cycle.
// - Writing zero to the charge voltage restores its pin default and forces the charge current to zero.
// - Charge voltage is 11 bits: high byte bits 6-0 hold bits 10-4, low byte bits 7-4 hold bits 3-0.
// - A 1 in a reserved upper bit of either high byte makes the write invalid.
// - Reserved low bits (3-0 charge voltage, 7-0 floor voltage) are ignored on write.
// - Floor voltage writes from 1.024 V to 16.128 V in 256 mV steps are accepted.
// - Floor voltage writes below 1.024 V or above 16.128 V are discarded.
// - At power-on the floor voltage loads 3.584, 6.144, 9.216 or 12.288 V from the cell-count pin.
// - Floor voltage is 6 bits in high byte bits 5-0, weights 8192 mV down to 256 mV.
`ifndef CMV_DEFINES_SVH
`define CMV_DEFINES_SVH

`define CMV_ADDR_CV_LO 8'h04
`define CMV_ADDR_CV_HI 8'h05
`define CMV_ADDR_MS_LO 8'h0C
`define CMV_ADDR_MS_HI 8'h0D

`define CMV_CV_HI_RSVD 8'h80
`define CMV_MS_HI_RSVD 8'hC0
`define CMV_CV_LO_SHIFT 4

`define CMV_CV_MIN 11'h040
`define CMV_CV_MAX 11'h4B0
`define CMV_CV_DEF_1S 11'h106
`define CMV_CV_DEF_2S 11'h20D
`define CMV_CV_DEF_3S 11'h313
`define CMV_CV_DEF_4S 11'h41A

`define CMV_MS_MIN 6'h04
`define CMV_MS_MAX 6'h3F
`define CMV_MS_DEF_1S 6'h0E
`define CMV_MS_DEF_2S 6'h18
`define CMV_MS_DEF_3S 6'h24
`define CMV_MS_DEF_4S 6'h30

`endif

//--- inc/cmv_pkg.sv
package cmv_pkg;

  typedef logic [10:0] cmv_cv_t;
  typedef logic [5:0] cmv_ms_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] data;
  } cmv_req_s;

endpackage : cmv_pkg

//--- design/cmv_field_check.sv
`timescale 1ns/1ps
`default_nettype none
module cmv_field_check #(
  parameter int W = 11,
  parameter logic [W-1:0] MIN_CODE = '0,
  parameter logic [W-1:0] MAX_CODE = '1
) (
  input wire logic [W-1:0] field_i,
  input wire logic rsvd_set_i,
  output logic ok_o
);

  wire logic in_range;

  assign in_range = (field_i >= MIN_CODE) && (field_i <= MAX_CODE);
  assign ok_o = in_range && !rsvd_set_i;

endmodule : cmv_field_check
`default_nettype wire

//--- sim/cmv_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cmv_host_model (
  input wire logic clk_i,
  output cmv_pkg::cmv_req_s req_o,
  output logic cc_wr_o
);
  initial begin
    req_o = '0;
    cc_wr_o = 1'b0;
  end
  // One byte access held across its taking edge, then released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req_o <= '{wr: w, rd: !w, addr: a, data: d};
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask : xfer
  // Low byte then high byte of one command
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    xfer(1'b1, a, v[7:0]);
    xfer(1'b1, a + 8'h01, v[15:8]);
  endtask : wr16
  // Current write, issued only after the voltage command
  task automatic cc_write();
    @(posedge clk_i);
    cc_wr_o <= 1'b1;
    @(posedge clk_i);
    cc_wr_o <= 1'b0;
  endtask : cc_write
endmodule : cmv_host_model
`default_nettype wire

//--- sim/test_cmv_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_cmv_regs;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [1:0] pin = 2'h0;
  logic pgood = 1'b0;
  cmv_pkg::cmv_req_s req;
  logic cc_wr, rvalid, clr, start, prog, rej;
  logic [7:0] rdata;
  cmv_pkg::cmv_cv_t cv, ecv;
  cmv_pkg::cmv_ms_t ms, ems;
  logic [7:0] expq[$];
  int n_fail = 0;
  int checks = 0;
  int cycles = 0;
  int n_clr = 0;
  int n_start = 0;
  int n_rej = 0;
  logic [31:0] rng = 32'h0000F0D9;
  logic [31:0] r;
  int cvmv[4] = '{4192, 8400, 12592, 16800};
  int msmv[4] = '{3584, 6144, 9216, 12288};
  logic [15:0] cvv[6] = '{16'h03F0, 16'h4B10, 16'h0400, 16'h4B0F, 16'h8400, 16'h7FF0};
  logic [7:0] msv[6] = '{8'h03, 8'h04, 8'h3F, 8'h45, 8'h80, 8'h00};

  always #25 ref_clk_i = ~ref_clk_i;

  cmv_host_model host (.clk_i(ref_clk_i), .req_o(req), .cc_wr_o(cc_wr));

  cmv_regs uut (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .req_i(req),
    .cell_count_select_pin_i(pin), .input_power_good_i(pgood),
    .charge_current_write_i(cc_wr), .rdata_o(rdata), .rvalid_o(rvalid),
    .charge_voltage_setting_o(cv), .system_floor_voltage_setting_o(ms),
    .charge_current_clear_o(clr), .charge_start_o(start),
    .charge_voltage_programmed_o(prog), .write_rejected_o(rej)
  );

  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim

  // Read watcher, pulse counters and cycle ceiling
  always @(posedge ref_clk_i) begin
    cycles++;
    n_clr += (clr === 1'b1);
    n_start += (start === 1'b1);
    n_rej += (rej === 1'b1);
    if (rvalid === 1'b1) begin
      if (expq.size() == 0) begin
        chk("spare read", 16'(rdata), 16'hFFFF);
      end else begin
        chk("read byte", 16'(rdata), 16'(expq.pop_front()));
      end
    end
    if (cycles > 20000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    expq.push_back(e);
    host.xfer(1'b0, a, 8'h00);
  endtask : rd

  task automatic rdbk();
    rd(8'h04, {ecv[3:0], 4'h0});
    rd(8'h05, {1'b0, ecv[10:4]});
    rd(8'h0C, 8'h00);
    rd(8'h0D, {2'b00, ems});
    rd(8'h3A, 8'h00);
  endtask : rdbk

  task automatic see();
    @(posedge ref_clk_i);
    #1;
    chk("charge voltage", 16'(cv), 16'(ecv));
    chk("floor voltage", 16'(ms), 16'(ems));
  endtask : see

  task automatic do_reset(input logic [1:0] p);
    @(posedge ref_clk_i);
    pin <= p;
    resetn_i <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
  endtask : do_reset

  initial begin
    for (int p = 0; p < 4; p++) begin
      do_reset(p[1:0]);
      ecv = cmv_pkg::cmv_cv_t'(cvmv[p] / 16);
      ems = cmv_pkg::cmv_ms_t'(msmv[p] / 256);
      see();
      rdbk();
    end
    @(posedge ref_clk_i);
    pgood <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = xs();
      ecv = cmv_pkg::cmv_cv_t'(64 + r[15:0] % 1137);
      host.wr16(8'h04, {1'b0, ecv, r[19:16]});
      see();
      rdbk();
    end
    chk("programmed", 16'(prog), 16'h0001);
    for (int i = 0; i < 6; i++) begin
      host.wr16(8'h04, cvv[i]);
      if (i == 2 || i == 3) ecv = cvv[i][14:4];
      see();
      r = xs();
      host.wr16(8'h0C, {msv[i], r[7:0]});
      if (i == 1 || i == 2) ems = msv[i][5:0];
      see();
    end
    rdbk();
    chk("rejects", 16'(n_rej), 16'h0008);
    @(posedge ref_clk_i);
    pin <= 2'h1;
    host.wr16(8'h04, 16'h000F);
    ecv = cmv_pkg::cmv_cv_t'(cvmv[1] / 16);
    see();
    chk("current clear", 16'(n_clr), 16'h0001);
    host.cc_write();
    repeat (3) @(posedge ref_clk_i);
    chk("start", 16'(n_start), 16'h0001);
    pgood <= 1'b0;
    host.cc_write();
    repeat (4) @(posedge ref_clk_i);
    chk("no start", 16'(n_start), 16'h0001);
    chk("programmed drop", 16'(prog), 16'h0000);
    chk("reads left", 16'(expq.size()), 16'h0000);
    end_sim();
  end
endmodule : test_cmv_regs
`default_nettype wire
